// ==== i2cmx_pkg.sv ====
// constants and types for the i2c mux channel control block
package i2cmx_pkg;
  localparam logic [3:0] ADDR_FIXED_UPPER = 4'he;
  localparam int ADDR_SEL_WIDTH = 3;
  localparam int CHAN_COUNT = 4;
  localparam int BYTE_WIDTH = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SEL_ENABLE_POS = 2;
  localparam int SEL_HIGH_POS = 1;
  localparam int SEL_LOW_POS = 0;
  localparam int ALERT_LSB = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] CHAN_NONE = 4'h0;

  typedef enum logic [5:0] {
    I2CMX_IDLE = 6'b00_0001,
    I2CMX_ADDR = 6'b00_0010,
    I2CMX_ACK = 6'b00_0100,
    I2CMX_WRITE = 6'b00_1000,
    I2CMX_READ = 6'b01_0000,
    I2CMX_MACK = 6'b10_0000
  } i2cmx_state_type;
endpackage

// ==== i2cmx_sync_if.sv ====
// synchronised serial-bus events passed from the line front end to the core
`timescale 1ns/100ps
`default_nettype none
interface i2cmx_sync_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start_seen;
  logic stop_seen;
  logic [3:0] alert_n;
  modport front (output scl_rise, scl_fall, sda, start_seen, stop_seen,
    alert_n);
  modport core (input scl_rise, scl_fall, sda, start_seen, stop_seen,
    alert_n);
endinterface
`default_nettype wire

// ==== i2cmx_line_sync.sv ====
// two-flop synchronisers and edge/start/stop detection for the pins
`timescale 1ns/100ps
`default_nettype none
module i2cmx_line_sync (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [3:0] i_alert_n,
  i2cmx_sync_if.front o_ev
);
  logic [5:0] meta;
  logic [5:0] sync;
  logic scl_d;
  logic sda_d;
  logic [5:0] next_meta;
  logic [5:0] next_sync;

  always_comb begin
    next_meta = {i_alert_n, i_sda, i_scl};
    next_sync = meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 6'h3f;
      sync <= 6'h3f;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      scl_d <= sync[0];
      sda_d <= sync[1];
    end
  end

  assign o_ev.scl_rise = sync[0] & ~scl_d;
  assign o_ev.scl_fall = ~sync[0] & scl_d;
  assign o_ev.sda = sync[1];
  assign o_ev.start_seen = sync[0] & scl_d & ~sync[1] & sda_d;
  assign o_ev.stop_seen = sync[0] & scl_d & sync[1] & ~sda_d;
  assign o_ev.alert_n = sync[5:2];
endmodule
`default_nettype wire

// ==== i2cmx_top.sv ====
// target-side control logic of a four-channel serial-bus multiplexer
// Operation
// RULE_01: after start the address byte's last bit picks read (1) or write (0).
// RULE_02: each written data byte is stored; the last byte received is kept.
// RULE_03: the control register is writable and readable over the serial bus.
// RULE_04: bit 2 clear selects none; set, bits 1..0 give channel 0..3.
// RULE_05: at most one downstream channel is ever connected.
// RULE_06: a new selection is applied only at the next stop condition.
// RULE_07: master sends stop right after the control byte acknowledge.
// RULE_08: after power-on reset register reads zero and no channel connects.
// RULE_09: any low alert input drives the open-drain alert output low.
// RULE_10: alert detection works whether or not the channel is selected.
// RULE_11: bits 4..7 report channels 0..3 alert state, sampled at read.
// RULE_12: a status bit reads one when its input is low; any mix allowed.
// RULE_13: alerts are not latched; they clear when the inputs release.
// RULE_14: master polls every device on a flagged channel to clear alerts.
// RULE_15: alert inputs may be general-purpose inputs read the same way.
// RULE_16: combined alert output is the AND of the four active-low inputs.
// RULE_17: device acks every received byte; master acks or nacks read bytes.
// RULE_18: address is a fixed upper part plus three address-select pins.
// RULE_19: writes to bits 3..7 do not alter status; bit 3 reads zero.
// RULE_20: power-on reset is the only reset and idles the serial machine.
`timescale 1ns/100ps
`default_nettype none
module i2cmx_top (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [2:0] i_addr_sel,
  input wire logic i_chan0_alert_in_n,
  input wire logic i_chan1_alert_in_n,
  input wire logic i_chan2_alert_in_n,
  input wire logic i_chan3_alert_in_n,
  output logic [3:0] o_downstream_pair_en,
  output logic [2:0] o_ctrl_select,
  output logic o_alert_out,
  output logic o_alert_oe
);
  i2cmx_sync_if ev ();

  i2cmx_line_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_alert_n({i_chan3_alert_in_n, i_chan2_alert_in_n,
      i_chan1_alert_in_n, i_chan0_alert_in_n}),
    .o_ev(ev.front)
  );

  // one-hot decode of the selection field
  function automatic logic [3:0] decode_sel(input logic [2:0] sel);
    logic [3:0] hot;
    hot = i2cmx_pkg::CHAN_NONE;
    if (sel[i2cmx_pkg::SEL_ENABLE_POS]) begin // RULE_04
      hot[{sel[i2cmx_pkg::SEL_HIGH_POS], sel[i2cmx_pkg::SEL_LOW_POS]}] =
        1'b1; // RULE_05
    end
    return hot;
  endfunction

  // ----------------------------------------------------------------
  // serial target state
  // ----------------------------------------------------------------
  i2cmx_pkg::i2cmx_state_type state;
  i2cmx_pkg::i2cmx_state_type next_state;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic is_read;
  logic next_is_read;
  logic addr_phase;
  logic next_addr_phase;
  logic [2:0] ctrl_sel;
  logic [2:0] next_ctrl_sel;
  logic [3:0] chan_en;
  logic [3:0] next_chan_en;
  logic sda_oe;
  logic next_sda_oe;
  logic alert_oe;
  logic next_alert_oe;
  logic [6:0] my_addr;
  // address straps are pins too, so they pass two flops like the bus lines
  logic [2:0] strap_meta;
  logic [2:0] next_strap_meta;
  logic [2:0] strap_sync;
  logic [2:0] next_strap_sync;

  assign my_addr = {i2cmx_pkg::ADDR_FIXED_UPPER, strap_sync}; // RULE_18

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_is_read = is_read;
    next_addr_phase = addr_phase;
    next_ctrl_sel = ctrl_sel;
    next_chan_en = chan_en;
    next_sda_oe = sda_oe;
    next_alert_oe = ~&ev.alert_n; // RULE_09 RULE_10 RULE_13 RULE_16
    next_strap_meta = i_addr_sel;
    next_strap_sync = strap_meta;
    if (ev.stop_seen) begin
      next_state = i2cmx_pkg::I2CMX_IDLE;
      next_sda_oe = 1'b0;
      next_chan_en = decode_sel(ctrl_sel); // RULE_06
    end else if (ev.start_seen) begin
      next_state = i2cmx_pkg::I2CMX_ADDR;
      next_bit_cnt = '0;
      next_sda_oe = 1'b0;
      next_addr_phase = 1'b1;
    end else begin
      case (state)
        i2cmx_pkg::I2CMX_IDLE: begin
          next_sda_oe = 1'b0;
        end
        i2cmx_pkg::I2CMX_ADDR, i2cmx_pkg::I2CMX_WRITE: begin
          if (ev.scl_rise) begin
            next_shift = {shift[6:0], ev.sda};
          end
          if (ev.scl_fall && addr_phase) begin
            // the clock fall that closes a start carries no bit
            next_addr_phase = 1'b0;
          end else if (ev.scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == i2cmx_pkg::BIT_LAST) begin
              if (state == i2cmx_pkg::I2CMX_ADDR) begin
                if (shift[7:1] == my_addr) begin
                  next_is_read = shift[0]; // RULE_01
                  next_state = i2cmx_pkg::I2CMX_ACK;
                  next_sda_oe = 1'b1; // RULE_17
                end else begin
                  next_state = i2cmx_pkg::I2CMX_IDLE;
                end
              end else begin
                next_ctrl_sel = shift[2:0]; // RULE_02 RULE_03 RULE_19
                next_state = i2cmx_pkg::I2CMX_ACK;
                next_sda_oe = 1'b1; // RULE_17
              end
            end
          end
        end
        i2cmx_pkg::I2CMX_ACK: begin
          if (ev.scl_fall) begin
            next_bit_cnt = '0;
            next_addr_phase = 1'b0;
            if (is_read) begin
              // status sampled live at the start of each read byte
              next_shift = {~ev.alert_n, 1'b0, ctrl_sel}; // RULE_11 RULE_12 RULE_15
              next_state = i2cmx_pkg::I2CMX_READ;
              next_sda_oe = ~next_shift[7];
            end else begin
              next_state = i2cmx_pkg::I2CMX_WRITE;
              next_sda_oe = 1'b0;
            end
          end
        end
        i2cmx_pkg::I2CMX_READ: begin
          if (ev.scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shift = {shift[6:0], 1'b0};
            if (bit_cnt == i2cmx_pkg::BIT_LAST) begin
              next_state = i2cmx_pkg::I2CMX_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_sda_oe = ~shift[6];
            end
          end
        end
        i2cmx_pkg::I2CMX_MACK: begin
          if (ev.scl_rise) begin
            if (ev.sda) begin
              next_state = i2cmx_pkg::I2CMX_IDLE; // RULE_17
            end else begin
              next_state = i2cmx_pkg::I2CMX_ACK;
            end
          end
        end
        default: begin
          next_state = i2cmx_pkg::I2CMX_IDLE;
        end
      endcase
    end
  end

  // power-on reset clears everything and idles the machine
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= i2cmx_pkg::I2CMX_IDLE; // RULE_20
      shift <= i2cmx_pkg::CTRL_RESET;
      bit_cnt <= '0;
      is_read <= 1'b0;
      addr_phase <= 1'b0;
      ctrl_sel <= i2cmx_pkg::CTRL_RESET[2:0]; // RULE_08
      chan_en <= i2cmx_pkg::CHAN_NONE; // RULE_08
      sda_oe <= 1'b0;
      alert_oe <= 1'b0;
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      is_read <= next_is_read;
      addr_phase <= next_addr_phase;
      ctrl_sel <= next_ctrl_sel;
      chan_en <= next_chan_en;
      sda_oe <= next_sda_oe;
      alert_oe <= next_alert_oe;
      strap_meta <= next_strap_meta;
      strap_sync <= next_strap_sync;
    end
  end

  // open-drain pins only ever pull low, so the driven value stays zero
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda_out <= 1'b0;
      o_alert_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_alert_out <= 1'b0;
    end
  end

  assign o_sda_oe = sda_oe;
  assign o_downstream_pair_en = chan_en;
  assign o_ctrl_select = ctrl_sel;
  assign o_alert_oe = alert_oe;
endmodule
`default_nettype wire

// ==== i2cmx_assertions.sv ====
// port-level assertions for the mux control block
`timescale 1ns/100ps
`default_nettype none
module i2cmx_assertions (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_chan0_alert_in_n,
  input wire logic i_chan1_alert_in_n,
  input wire logic i_chan2_alert_in_n,
  input wire logic i_chan3_alert_in_n,
  input wire logic [3:0] o_downstream_pair_en,
  input wire logic [2:0] o_ctrl_select,
  input wire logic o_alert_out,
  input wire logic o_alert_oe
);
  // ------------------------------------------------------------
  // stop tracking
  // ------------------------------------------------------------
  logic sda_q;
  logic all_hi;
  logic [3:0] since_stop;
  logic [3:0] next_since_stop;
  assign all_hi = i_chan0_alert_in_n & i_chan1_alert_in_n &
    i_chan2_alert_in_n & i_chan3_alert_in_n;
  // cycles since sda rose with scl high, saturating
  always_comb begin
    next_since_stop = since_stop + {3'h0, since_stop != 4'hf};
    if (i_scl && i_sda && !sda_q) begin
      next_since_stop = 4'h0;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_q <= 1'b1;
      since_stop <= 4'hf;
    end else begin
      sda_q <= i_sda;
      since_stop <= next_since_stop;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_alert_on;
    ##[1:4] o_alert_oe;
  endsequence
  alert_on_a:
    assert property ($fell(all_hi) |-> s_alert_on) else $error("alert late");
  alert_off_a:
    assert property ($rose(all_hi) |-> ##[1:4] !o_alert_oe)
    else $error("alert stuck");
  one_channel_a:
    assert property ($onehot0(o_downstream_pair_en)) else $error("two on");
  apply_at_stop_a:
    assert property (!$stable(o_downstream_pair_en) |-> since_stop <= 4'h6)
    else $error("pair moved outside stop");
  decode_sel_a:
    assert property (since_stop == 4'h8 |-> o_downstream_pair_en ==
      (o_ctrl_select[2] ? 4'h1 << o_ctrl_select[1:0] : 4'h0))
    else $error("bad decode");
  sda_scl_low_a:
    assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved");
  open_drain_a:
    assert property (!o_sda_out && !o_alert_out) else $error("drives high");
  reset_clear_a:
    assert property ($rose(i_arst_n) |-> o_downstream_pair_en == 4'h0 &&
      o_ctrl_select == 3'h0 && !o_sda_oe) else $error("reset state");
endmodule
bind i2cmx_top i2cmx_assertions u_i2cmx_assertions (.i_clk_sys, .i_arst_n,
  .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_chan0_alert_in_n,
  .i_chan1_alert_in_n, .i_chan2_alert_in_n, .i_chan3_alert_in_n,
  .o_downstream_pair_en, .o_ctrl_select, .o_alert_out, .o_alert_oe);
`default_nettype wire

// ==== i2cmx_master_model.sv ====
// serial-bus master model: scl idles high, sda released reads one
`timescale 1ns/100ps
`default_nettype none
module i2cmx_master_model (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = ~b;
    #31.2 o_scl = 1'b1;
    #62.5 r = i_sda;
    o_scl = 1'b0;
    #31.3;
  endtask
  task automatic start_cond();
    // offset keeps every pin change off the system clock's rising edge
    #2;
    o_sda_oe = 1'b0;
    #31.2 o_scl = 1'b1;
    #62.5 o_sda_oe = 1'b1;
    #62.5 o_scl = 1'b0;
    #31.3;
  endtask
  task automatic stop_cond();
    o_sda_oe = 1'b1;
    #31.2 o_scl = 1'b1;
    #62.5 o_sda_oe = 1'b0;
    #62.5;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
  endtask
endmodule
`default_nettype wire

// ==== i2cmx_top_bench.sv ====
// self-checking bench for the mux control block
`timescale 1ns/100ps
`default_nettype none
module i2cmx_top_bench;
  localparam logic [6:0] DEV = {i2cmx_pkg::ADDR_FIXED_UPPER, 3'h5};
  typedef struct packed {
    logic [7:0] wdata;
    logic [3:0] alert_n;
    logic [3:0] pair;
  } i2cmx_row_type;
  i2cmx_row_type rows [5] = '{'{8'h04, 4'hf, 4'h1}, '{8'h05, 4'he, 4'h2},
    '{8'hfe, 4'h5, 4'h4}, '{8'h07, 4'h7, 4'h8}, '{8'h0b, 4'h0, 4'h0}};
  i2cmx_row_type r;
  logic i_clk_sys, i_arst_n, o_sda_out, o_sda_oe, o_alert_out, o_alert_oe;
  logic m_oe, i_scl;
  logic [2:0] i_addr_sel, o_ctrl_select;
  logic [3:0] alert_n, o_downstream_pair_en, prev;
  logic [8:0] q;
  int mismatches = 0, compares = 0, cycles = 0;
  wire logic i_sda = ~(m_oe | o_sda_oe);
  i2cmx_top u_i2cmx_top (.i_clk_sys, .i_arst_n, .i_scl, .i_sda, .o_sda_out,
    .o_sda_oe, .i_addr_sel, .i_chan0_alert_in_n(alert_n[0]),
    .i_chan1_alert_in_n(alert_n[1]), .i_chan2_alert_in_n(alert_n[2]),
    .i_chan3_alert_in_n(alert_n[3]), .o_downstream_pair_en, .o_ctrl_select,
    .o_alert_out, .o_alert_oe);
  i2cmx_master_model u_i2cmx_master_model (.o_scl(i_scl), .o_sda_oe(m_oe),
    .i_sda);
  task automatic chk(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic addr(input logic rw);
    u_i2cmx_master_model.start_cond();
    u_i2cmx_master_model.xfer({DEV, rw, 1'b1}, q);
    chk("addr ack", 8'h00, {7'h0, q[0]});
  endtask
  task automatic wbyte(input logic [7:0] d);
    u_i2cmx_master_model.xfer({d, 1'b1}, q);
    chk("data ack", 8'h00, {7'h0, q[0]});
  endtask
  task automatic rd(input logic [7:0] exp);
    addr(1'b1);
    u_i2cmx_master_model.xfer(9'h1ff, q);
    u_i2cmx_master_model.stop_cond();
    chk("read", exp, q[8:1]);
  endtask
  task automatic settle();
    u_i2cmx_master_model.stop_cond();
    repeat (8) @(posedge i_clk_sys);
  endtask
  initial begin
    i_arst_n = 1'b0;
    i_addr_sel = 3'h5;
    alert_n = 4'hf;
    prev = 4'h0;
    repeat (12) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(8'h00);
    $display("reset default test done");
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge i_clk_sys) alert_n <= r.alert_n;
      addr(1'b0);
      wbyte(r.wdata);
      chk("held", {4'h0, prev}, {4'h0, o_downstream_pair_en});
      settle();
      chk("pair", {4'h0, r.pair}, {4'h0, o_downstream_pair_en});
      rd({~r.alert_n, 1'b0, r.wdata[2:0]});
      chk("alert", {7'h0, r.alert_n != 4'hf}, {7'h0, o_alert_oe});
      prev = r.pair;
      $display("row %0d done", i);
    end
    addr(1'b0);
    wbyte(8'h04);
    wbyte(8'h06);
    settle();
    chk("last byte", 8'h04, {4'h0, o_downstream_pair_en});
    u_i2cmx_master_model.start_cond();
    u_i2cmx_master_model.xfer({4'he, 3'h2, 2'b01}, q);
    chk("no ack", 8'h01, {7'h0, q[0]});
    settle();
    i_addr_sel <= 3'h2;
    u_i2cmx_master_model.start_cond();
    u_i2cmx_master_model.xfer({4'he, 3'h2, 2'b01}, q);
    chk("strap ack", 8'h00, {7'h0, q[0]});
    settle();
    i_addr_sel <= 3'h5;
    @(posedge i_clk_sys) alert_n <= 4'hf;
    repeat (8) @(posedge i_clk_sys);
    chk("released", 8'h00, {7'h0, o_alert_oe});
    rd(8'h06);
    $display("multi byte, address and release tests done");
    @(posedge i_clk_sys) i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    chk("reset", 8'h00, {1'b0, o_ctrl_select, o_downstream_pair_en});
    @(posedge i_clk_sys) i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(8'h00);
    $display("mid-run reset test done");
    test_done();
  end
endmodule
`default_nettype wire
